// [sswl_pkg.sv]
// Constants shared by the stamp and write-lock register bank
// How it works
// - Channels 6 to 8 each hold a read-only stamp as a high and a low byte.
// - Stamps are taken only while a pin-launched sequence runs.
// - In a code 01 sequence a rail rising past slow undervoltage stamps.
// - In a code 10 sequence a rail falling past the off level stamps.
// - The sequence timer advances one count per 50 us tick.
// - Page bit 0 picks bank 0 or 1, bits 7 to 1 read zero, reset is zero.
// - A group locks only when its bit is set in both write-lock registers.
// - Write-lock registers reset to zero; the host cannot clear a set bit.
// - Locks clear only on power cycle, commanded reset or shutdown self-test.
// - Lock bits 5 to 0: control, order work, config, irq, channel, order.
// - Bits 7 and 6 of both write-lock registers read zero and ignore writes.
// - With the channel group locked, only selected channels are blocked.
// - Channel lock select resets to 0xC1 with bits 7 and 6 read-only.
// - Bus id: low 3 bits from the strap, upper bits from one-time memory when valid, else the factory value.
// - Supervisor control bit 3 written one resets the device and reads zero.
package sswl_pkg;

   // Bank 0 register offsets
   localparam logic [7:0] OFS_CH6_HI        = 8'h9A;
   localparam logic [7:0] OFS_CH6_LO        = 8'h9B;
   localparam logic [7:0] OFS_CH7_HI        = 8'h9C;
   localparam logic [7:0] OFS_CH7_LO        = 8'h9D;
   localparam logic [7:0] OFS_CH8_HI        = 8'h9E;
   localparam logic [7:0] OFS_CH8_LO        = 8'h9F;
   localparam logic [7:0] OFS_PAGE_SELECT   = 8'hF0;
   localparam logic [7:0] OFS_LOCK_PRIMARY  = 8'hF1;
   localparam logic [7:0] OFS_LOCK_SECOND   = 8'hF2;
   localparam logic [7:0] OFS_CHAN_LOCK_SEL = 8'hF3;
   localparam logic [7:0] OFS_BUS_ID        = 8'hF9;

   // Bank 1 register offsets
   localparam logic [7:0] OFS_SUPV_CONTROL  = 8'h10;
   localparam logic [7:0] OFS_TEST_CONFIG   = 8'h12;

   // Field positions
   localparam int BIT_PAGE            = 0;
   localparam int BIT_FULL_RESET      = 3;
   localparam int BIT_SELFTEST_SHDN   = 3;
   localparam int BIT_CTRL_WORK_LOCK  = 5;
   localparam int BIT_ORD_WORK_LOCK   = 4;
   localparam int BIT_CFG_GROUP_LOCK  = 3;
   localparam int BIT_IRQ_EN_LOCK     = 2;
   localparam int BIT_CHAN_CFG_LOCK   = 1;
   localparam int BIT_ORD_GROUP_LOCK  = 0;
   localparam int LOCK_W              = 6;
   localparam int STRAP_W             = 3;
   localparam int NVM_W               = 4;
   localparam int STAMP_W             = 16;

   // Reset values
   localparam logic [7:0]        RST_PAGE_SELECT   = 8'h00;
   localparam logic [LOCK_W-1:0] RST_LOCK          = 6'h00;
   localparam logic [7:0]        RST_CHAN_LOCK_SEL = 8'hC1;
   localparam logic [STAMP_W-1:0] RST_STAMP        = 16'h0000;

   // Factory bus id upper bits, used whenever one-time memory does not report valid
   localparam logic [NVM_W-1:0] NVM_FACTORY_UPPER = NVM_W'(30 >> 1);

   // Sequence request codes on the request and sleep pins
   localparam logic [1:0] CODE_SEQ_UP   = 2'b01;
   localparam logic [1:0] CODE_SEQ_DOWN = 2'b10;

   // Timing: 50 us tick at a 20 ns clock
   localparam int TICK_US     = 50;
   localparam int CLK_PER_NS  = 20;
   localparam int TICK_CYCLES = (TICK_US * 1000 + CLK_PER_NS - 1) / CLK_PER_NS;
   localparam int TICK_CNT_W  = $clog2(TICK_CYCLES);

   // Sequence states
   typedef enum logic [1:0] {
      SSWL_SEQ_IDLE,
      SSWL_SEQ_UP,
      SSWL_SEQ_DOWN
   } sswl_seq_t;

endpackage : sswl_pkg

// [sswl_tick_timer.sv]
// Sequence timer counting 50 us ticks while a sequence runs
`timescale 1ns/100ps
module sswl_tick_timer
   import sswl_pkg::*;
(
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               srst,
   // Control
   input  wire logic               run,
   // Timer value
   output      logic [STAMP_W-1:0] time_ff
);

   logic [TICK_CNT_W-1:0] presc_ff;
   logic [TICK_CNT_W-1:0] nxt_presc;
   logic [STAMP_W-1:0]    nxt_time;
   wire                   tick_wrap;
   wire                   time_full;

   // Prescaler wraps once per tick; timer holds at full scale
   assign tick_wrap = (presc_ff == TICK_CNT_W'(TICK_CYCLES - 1));
   assign time_full = &time_ff;
   assign nxt_presc = !run ? '0 : tick_wrap ? '0
                    : presc_ff + TICK_CNT_W'(1);
   assign nxt_time  = !run ? RST_STAMP
                    : (tick_wrap && !time_full) ? time_ff + STAMP_W'(1)
                    : time_ff;

   // Idle clears the count so every sequence starts at zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         presc_ff <= '0;
         time_ff  <= RST_STAMP;
      end else begin
         presc_ff <= nxt_presc;
         time_ff  <= nxt_time;
      end
   end

endmodule : sswl_tick_timer

// [sswl_stamp_chan.sv]
// One channel's stamp capture on its threshold crossing
`timescale 1ns/100ps
module sswl_stamp_chan
   import sswl_pkg::*;
(
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               srst,
   // Sequence state
   input  wire logic               seq_start,
   input  wire logic               seq_up,
   input  wire logic               seq_down,
   // Comparator levels
   input  wire logic               above_uv,
   input  wire logic               above_off,
   // Timer and stored stamp
   input  wire logic [STAMP_W-1:0] time_now,
   output      logic [STAMP_W-1:0] stamp_ff
);

   logic uv_q_ff;
   logic off_q_ff;
   logic done_ff;
   wire  rise_uv;
   wire  fall_off;
   wire  capture;

   // Edge detect on comparator levels; first crossing per sequence wins
   assign rise_uv  = seq_up && above_uv && !uv_q_ff;
   assign fall_off = seq_down && !above_off && off_q_ff;
   assign capture  = (rise_uv || fall_off) && !done_ff;

   // Old stamp stays readable until the next crossing overwrites it
   always_ff @(posedge core_clk) begin
      if (srst) begin
         uv_q_ff  <= 1'b0;
         off_q_ff <= 1'b0;
         done_ff  <= 1'b0;
         stamp_ff <= RST_STAMP;
      end else begin
         uv_q_ff  <= above_uv;
         off_q_ff <= above_off;
         if (seq_start) begin
            done_ff <= 1'b0;
         end else if (capture) begin
            done_ff  <= 1'b1;
            stamp_ff <= time_now;
         end
      end
   end

endmodule : sswl_stamp_chan

// [sswl_top.sv]
// Stamp registers, page select and dual write-lock register bank
`timescale 1ns/100ps
module sswl_top
   import sswl_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              srst,
   // Register port from the serial front end
   input  wire logic              reg_wr_en,
   input  wire logic              reg_rd_en,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output      logic [7:0]        reg_rdata_ff,
   output      logic              reg_rvalid_ff,
   // Sequence launch pins
   input  wire logic [1:0]        power_state_request_pin,
   input  wire logic [1:0]        sleep_pin,
   // Comparator levels for channels 6 to 8
   input  wire logic [2:0]        above_slow_uv,
   input  wire logic [2:0]        above_off_level,
   // Self-test and address sources
   input  wire logic              selftest_exit_seq2,
   input  wire logic [STRAP_W-1:0] addr_strap,
   input  wire logic [NVM_W-1:0]  bus_id_upper_bits_nvm,
   input  wire logic              nvm_valid,
   // Lock and bank outputs to the rest of the device
   output      logic              page_select_ff,
   output      logic [LOCK_W-1:0] group_locked_ff,
   output      logic [LOCK_W-1:0] chan_write_block_ff,
   output      logic              full_reset_ff,
   output      logic [6:0]        bus_id_ff
);

   // Sequence tracking
   sswl_seq_t  seq_ff;
   sswl_seq_t  nxt_seq;
   logic [1:0] req_prev_ff;
   logic [1:0] slp_prev_ff;
   logic       seq_start_ff;

   // Register state
   logic [LOCK_W-1:0] lock_pri_ff;
   logic [LOCK_W-1:0] lock_sec_ff;
   logic [5:0]        chan_sel_ff;
   logic              selftest_shdn_ff;
   logic              strap_taken_ff;
   logic [STRAP_W-1:0] strap_ff;

   // Stamps
   logic [STAMP_W-1:0] time_now;
   logic [STAMP_W-1:0] stamp [3];

   wire soft_rst;
   wire lock_clear;
   wire launch_up;
   wire launch_down;
   wire up_held;
   wire down_held;
   wire bank0;
   wire bank1;
   wire wr_page;
   wire wr_pri;
   wire wr_sec;
   wire wr_chan;
   wire wr_ctrl;
   wire wr_test;
   wire [LOCK_W-1:0] both_locks;
   wire [LOCK_W-1:0] nxt_pri;
   wire [LOCK_W-1:0] nxt_sec;
   wire [6:0]        nxt_bus_id;
   wire [NVM_W-1:0]  upper_bits;
   logic [7:0]       nxt_rdata;

   // Commanded full reset clears bank state one cycle after the write
   assign soft_rst   = srst || full_reset_ff;
   assign lock_clear = soft_rst
                    || (selftest_exit_seq2 && selftest_shdn_ff);

   // Launch on a new code from either pin
   assign launch_up   = (power_state_request_pin == CODE_SEQ_UP
                         && req_prev_ff != CODE_SEQ_UP)
                     || (sleep_pin == CODE_SEQ_UP
                         && slp_prev_ff != CODE_SEQ_UP);
   assign launch_down = (power_state_request_pin == CODE_SEQ_DOWN
                         && req_prev_ff != CODE_SEQ_DOWN)
                     || (sleep_pin == CODE_SEQ_DOWN
                         && slp_prev_ff != CODE_SEQ_DOWN);
   assign up_held     = power_state_request_pin == CODE_SEQ_UP
                     || sleep_pin == CODE_SEQ_UP;
   assign down_held   = power_state_request_pin == CODE_SEQ_DOWN
                     || sleep_pin == CODE_SEQ_DOWN;

   // Sequence state: a new launch restarts, a dropped code ends it
   always_comb begin
      nxt_seq = seq_ff;
      case (seq_ff)
         SSWL_SEQ_IDLE: begin
            if (launch_up) begin
               nxt_seq = SSWL_SEQ_UP;
            end else if (launch_down) begin
               nxt_seq = SSWL_SEQ_DOWN;
            end
         end
         SSWL_SEQ_UP: begin
            if (launch_down) begin
               nxt_seq = SSWL_SEQ_DOWN;
            end else if (!up_held) begin
               nxt_seq = SSWL_SEQ_IDLE;
            end
         end
         SSWL_SEQ_DOWN: begin
            if (launch_up) begin
               nxt_seq = SSWL_SEQ_UP;
            end else if (!down_held) begin
               nxt_seq = SSWL_SEQ_IDLE;
            end
         end
         default: begin
            nxt_seq = SSWL_SEQ_IDLE;
         end
      endcase
   end

   // Sequence registers; start pulse resets the timer for one cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         seq_ff       <= SSWL_SEQ_IDLE;
         req_prev_ff  <= 2'h0;
         slp_prev_ff  <= 2'h0;
         seq_start_ff <= 1'b0;
      end else begin
         seq_ff       <= nxt_seq;
         req_prev_ff  <= power_state_request_pin;
         slp_prev_ff  <= sleep_pin;
         seq_start_ff <= launch_up || launch_down;
      end
   end

   // Timer runs only inside a sequence
   sswl_tick_timer u_timer (
      .core_clk (core_clk),
      .srst     (srst || seq_start_ff),
      .run      (seq_ff != SSWL_SEQ_IDLE),
      .time_ff  (time_now)
   );

   // One capture unit per stamped channel
   for (genvar ch = 0; ch < 3; ch++) begin : g_chan
      sswl_stamp_chan u_chan (
         .core_clk  (core_clk),
         .srst      (srst),
         .seq_start (seq_start_ff),
         .seq_up    (seq_ff == SSWL_SEQ_UP),
         .seq_down  (seq_ff == SSWL_SEQ_DOWN),
         .above_uv  (above_slow_uv[ch]),
         .above_off (above_off_level[ch]),
         .time_now  (time_now),
         .stamp_ff  (stamp[ch])
      );
   end

   // Address decode; lock registers are visible in both banks
   assign bank0   = !page_select_ff;
   assign bank1   = page_select_ff;
   assign wr_page = reg_wr_en && reg_addr == OFS_PAGE_SELECT;
   assign wr_pri  = reg_wr_en && reg_addr == OFS_LOCK_PRIMARY;
   assign wr_sec  = reg_wr_en && reg_addr == OFS_LOCK_SECOND;
   assign wr_chan = reg_wr_en && reg_addr == OFS_CHAN_LOCK_SEL;
   assign wr_ctrl = reg_wr_en && bank1 && reg_addr == OFS_SUPV_CONTROL;
   assign wr_test = reg_wr_en && bank1 && reg_addr == OFS_TEST_CONFIG;

   // Host may only set lock bits; zeros written are dropped
   assign nxt_pri = lock_clear ? RST_LOCK
                  : wr_pri ? lock_pri_ff | reg_wdata[LOCK_W-1:0]
                  : lock_pri_ff;
   assign nxt_sec = lock_clear ? RST_LOCK
                  : wr_sec ? lock_sec_ff | reg_wdata[LOCK_W-1:0]
                  : lock_sec_ff;
   assign both_locks = lock_pri_ff & lock_sec_ff;

   // Strap caught after reset release; memory bits fall back to factory
   assign upper_bits = nvm_valid ? bus_id_upper_bits_nvm : NVM_FACTORY_UPPER;
   assign nxt_bus_id = {upper_bits, strap_ff};

   // Bank state registers
   always_ff @(posedge core_clk) begin
      if (soft_rst) begin
         page_select_ff   <= RST_PAGE_SELECT[BIT_PAGE];
         chan_sel_ff      <= RST_CHAN_LOCK_SEL[5:0];
         selftest_shdn_ff <= 1'b0;
      end else begin
         if (wr_page) begin
            page_select_ff <= reg_wdata[BIT_PAGE];
         end
         if (wr_chan) begin
            chan_sel_ff <= reg_wdata[5:0];
         end
         if (wr_test) begin
            selftest_shdn_ff <= reg_wdata[BIT_SELFTEST_SHDN];
         end
      end
   end

   // Lock registers and lock outputs
   always_ff @(posedge core_clk) begin
      if (srst) begin
         lock_pri_ff         <= RST_LOCK;
         lock_sec_ff         <= RST_LOCK;
         group_locked_ff     <= RST_LOCK;
         chan_write_block_ff <= RST_LOCK;
      end else begin
         lock_pri_ff         <= nxt_pri;
         lock_sec_ff         <= nxt_sec;
         group_locked_ff     <= both_locks;
         chan_write_block_ff <= both_locks[BIT_CHAN_CFG_LOCK]
                              ? chan_sel_ff : '0;
      end
   end

   // Full reset pulse, strap capture and bus id
   always_ff @(posedge core_clk) begin
      if (srst) begin
         full_reset_ff  <= 1'b0;
         strap_taken_ff <= 1'b0;
         strap_ff       <= '0;
         bus_id_ff      <= 7'h00;
      end else begin
         full_reset_ff  <= wr_ctrl && reg_wdata[BIT_FULL_RESET];
         strap_taken_ff <= 1'b1;
         if (!strap_taken_ff) begin
            strap_ff <= addr_strap;
         end
         bus_id_ff <= nxt_bus_id;
      end
   end

   // Read mux; unmapped, reserved and reset bit all read zero
   always_comb begin
      nxt_rdata = 8'h00;
      if (bank0 && reg_addr == OFS_CH6_HI) begin
         nxt_rdata = stamp[0][15:8];
      end else if (bank0 && reg_addr == OFS_CH6_LO) begin
         nxt_rdata = stamp[0][7:0];
      end else if (bank0 && reg_addr == OFS_CH7_HI) begin
         nxt_rdata = stamp[1][15:8];
      end else if (bank0 && reg_addr == OFS_CH7_LO) begin
         nxt_rdata = stamp[1][7:0];
      end else if (bank0 && reg_addr == OFS_CH8_HI) begin
         nxt_rdata = stamp[2][15:8];
      end else if (bank0 && reg_addr == OFS_CH8_LO) begin
         nxt_rdata = stamp[2][7:0];
      end else if (reg_addr == OFS_PAGE_SELECT) begin
         nxt_rdata = {7'h00, page_select_ff};
      end else if (reg_addr == OFS_LOCK_PRIMARY) begin
         nxt_rdata = {2'b00, lock_pri_ff};
      end else if (reg_addr == OFS_LOCK_SECOND) begin
         nxt_rdata = {2'b00, lock_sec_ff};
      end else if (reg_addr == OFS_CHAN_LOCK_SEL) begin
         nxt_rdata = {RST_CHAN_LOCK_SEL[7:6], chan_sel_ff};
      end else if (reg_addr == OFS_BUS_ID) begin
         nxt_rdata = {1'b0, bus_id_ff};
      end else if (bank1 && reg_addr == OFS_TEST_CONFIG) begin
         nxt_rdata = {4'h0, selftest_shdn_ff, 3'h0};
      end
   end

   // Read data lands one cycle after the read strobe
   always_ff @(posedge core_clk) begin
      if (srst) begin
         reg_rdata_ff  <= 8'h00;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end

endmodule : sswl_top

// [sswl_monitor.sv]
// Port-level concurrent checks for the stamp and write-lock register bank
`timescale 1ns/100ps
module sswl_monitor
   import sswl_pkg::*;
(
   // Clock and reset
   input wire logic               core_clk,
   input wire logic               srst,
   // Register port
   input wire logic               reg_wr_en,
   input wire logic               reg_rd_en,
   input wire logic [7:0]         reg_addr,
   input wire logic [7:0]         reg_wdata,
   input wire logic [7:0]         reg_rdata_ff,
   input wire logic               reg_rvalid_ff,
   // Side inputs
   input wire logic               selftest_exit_seq2,
   input wire logic [STRAP_W-1:0] addr_strap,
   input wire logic [NVM_W-1:0]   bus_id_upper_bits_nvm,
   input wire logic               nvm_valid,
   // Outputs under watch
   input wire logic               page_select_ff,
   input wire logic [LOCK_W-1:0]  group_locked_ff,
   input wire logic               full_reset_ff,
   input wire logic [6:0]         bus_id_ff
);
   default clocking mon_cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   // Host reset command seen on the register port and the pulse it raises
   sequence s_reset_cmd;
      reg_wr_en && page_select_ff && reg_addr == OFS_SUPV_CONTROL
         && reg_wdata[BIT_FULL_RESET];
   endsequence
   sequence s_reset_pulse;
      full_reset_ff ##1 !full_reset_ff;
   endsequence

   property p_page_write;
      reg_wr_en && reg_addr == OFS_PAGE_SELECT
         |=> page_select_ff == $past(reg_wdata[BIT_PAGE]);
   endproperty
   a_page_write: assert property (p_page_write)
      else $error("page select did not follow write");

   property p_page_read;
      reg_rvalid_ff && $past(reg_addr) == OFS_PAGE_SELECT
         |-> reg_rdata_ff == {7'h00, page_select_ff};
   endproperty
   a_page_read: assert property (p_page_read)
      else $error("page select read value wrong");

   property p_lock_reserved;
      reg_rvalid_ff && ($past(reg_addr) == OFS_LOCK_PRIMARY
         || $past(reg_addr) == OFS_LOCK_SECOND) |-> reg_rdata_ff[7:6] == 2'h0;
   endproperty
   a_lock_reserved: assert property (p_lock_reserved)
      else $error("lock register reserved bits set");

   // A group can only lock two cycles after a lock register write
   property p_lock_rise;
      |(group_locked_ff & ~$past(group_locked_ff)) |-> $past(reg_wr_en, 2)
         && ($past(reg_addr, 2) == OFS_LOCK_PRIMARY
         || $past(reg_addr, 2) == OFS_LOCK_SECOND);
   endproperty
   a_lock_rise: assert property (p_lock_rise)
      else $error("group lock rose without a lock write");

   // Reset windows are excluded since clearing lags the cause
   property p_lock_no_drop;
      !$past(srst, 1) && !$past(srst, 2) && !$past(full_reset_ff, 1)
         && !$past(full_reset_ff, 2) && !$past(full_reset_ff, 3)
         && !$past(selftest_exit_seq2, 1) && !$past(selftest_exit_seq2, 2)
         && !$past(selftest_exit_seq2, 3)
         |-> (group_locked_ff & $past(group_locked_ff))
            == $past(group_locked_ff);
   endproperty
   a_lock_no_drop: assert property (p_lock_no_drop)
      else $error("group lock cleared without a clearing event");

   property p_full_reset;
      s_reset_cmd |=> s_reset_pulse;
   endproperty
   a_full_reset: assert property (p_full_reset)
      else $error("full reset pulse missing or too long");

   property p_bus_id;
      $fell(srst) |-> ##[1:3] bus_id_ff == {nvm_valid ?
         bus_id_upper_bits_nvm : NVM_FACTORY_UPPER, addr_strap};
   endproperty
   a_bus_id: assert property (p_bus_id)
      else $error("bus id not built from strap and memory");

   property p_unmapped_read;
      reg_rd_en && reg_addr == 8'h50
         |=> reg_rvalid_ff && reg_rdata_ff == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not zero");
endmodule : sswl_monitor

// [sswl_host_model.sv]
// Host controller model driving the register port
`timescale 1ns/100ps
module sswl_host_model (
   // Clock
   input  wire logic       core_clk,
   // Requests
   output      logic       reg_wr_en,
   output      logic       reg_rd_en,
   output      logic [7:0] reg_addr,
   output      logic [7:0] reg_wdata,
   // Answer
   input  wire logic [7:0] reg_rdata_ff,
   input  wire logic       reg_rvalid_ff
);
   // Idle port at time zero
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // One-cycle strobe; released lines are scrambled, not left holding
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #2;
      reg_wr_en = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(posedge core_clk);
      #2;
      reg_wr_en = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask : wr

   // Answer is registered, so it is present right after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic ok);
      @(posedge core_clk);
      #2;
      reg_rd_en = 1'b1;
      reg_addr  = a;
      @(posedge core_clk);
      #2;
      reg_rd_en = 1'b0;
      reg_addr  = ~a;
      d  = reg_rdata_ff;
      ok = reg_rvalid_ff;
   endtask : rd
endmodule : sswl_host_model

// [sswl_tb_top.sv]
// Self-checking bench for the stamp and write-lock register bank
`timescale 1ns/100ps
bind sswl_top sswl_monitor sswl_monitor_inst (.core_clk(core_clk),
   .srst(srst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
   .reg_rvalid_ff(reg_rvalid_ff), .selftest_exit_seq2(selftest_exit_seq2),
   .addr_strap(addr_strap), .bus_id_upper_bits_nvm(bus_id_upper_bits_nvm),
   .nvm_valid(nvm_valid), .page_select_ff(page_select_ff),
   .group_locked_ff(group_locked_ff), .full_reset_ff(full_reset_ff),
   .bus_id_ff(bus_id_ff));

module sswl_tb_top;
   import sswl_pkg::*;
   typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] val;}
      sswl_row_t;
   localparam logic [3:0] NVM_SET = 4'hA;
   localparam logic [2:0] STRAP_SET = 3'h5;
   localparam logic [7:0] BUS_ID = {1'b0, NVM_SET, STRAP_SET};
   logic core_clk = 1'b0, srst, reg_wr_en, reg_rd_en, reg_rvalid_ff;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
   logic [1:0] power_state_request_pin, sleep_pin;
   logic [2:0] above_slow_uv, above_off_level;
   logic selftest_exit_seq2, page_select_ff, full_reset_ff, nvm_valid;
   logic [LOCK_W-1:0] group_locked_ff, chan_write_block_ff;
   logic [6:0] bus_id_ff;
   int n_mismatch = 0;
   int comparisons = 0;
   // Reads then writes with read-back; a write row's value is its data
   sswl_row_t rows [20] = '{{1'b0, 8'hF0, 8'h00}, {1'b0, 8'hF1, 8'h00},
      {1'b0, 8'hF2, 8'h00}, {1'b0, 8'hF3, 8'hC1}, {1'b0, 8'hF9, BUS_ID},
      {1'b0, 8'h9A, 8'h00}, {1'b0, 8'h9F, 8'h00}, {1'b0, 8'h50, 8'h00},
      {1'b1, 8'hF0, 8'hFF}, {1'b0, 8'hF0, 8'h01}, {1'b1, 8'hF0, 8'h00},
      {1'b0, 8'hF0, 8'h00}, {1'b1, 8'hF9, 8'hFF}, {1'b0, 8'hF9, BUS_ID},
      {1'b1, 8'h9B, 8'h5A}, {1'b0, 8'h9B, 8'h00}, {1'b1, 8'hF3, 8'hFF},
      {1'b0, 8'hF3, 8'hFF}, {1'b1, 8'hF3, 8'hC1}, {1'b0, 8'hF3, 8'hC1}};

   always #10 core_clk = ~core_clk;

   sswl_host_model sswl_host_model_inst (.core_clk(core_clk),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .reg_rvalid_ff(reg_rvalid_ff));

   sswl_top sswl_top_inst (.core_clk(core_clk), .srst(srst),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .reg_rvalid_ff(reg_rvalid_ff),
      .power_state_request_pin(power_state_request_pin),
      .sleep_pin(sleep_pin), .above_slow_uv(above_slow_uv),
      .above_off_level(above_off_level),
      .selftest_exit_seq2(selftest_exit_seq2), .addr_strap(STRAP_SET),
      .bus_id_upper_bits_nvm(NVM_SET), .nvm_valid(nvm_valid),
      .page_select_ff(page_select_ff), .group_locked_ff(group_locked_ff),
      .chan_write_block_ff(chan_write_block_ff),
      .full_reset_ff(full_reset_ff), .bus_id_ff(bus_id_ff));

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t value %h, wanted %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t flag %b, wanted %b", $time, got, exp);
      end
   endtask : chk1

   task automatic expect_rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      sswl_host_model_inst.rd(a, d, ok);
      chk1(ok, 1'b1);
      chk8(d, exp);
   endtask : expect_rd

   // Advance n edges, then step off the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask : cyc

   task automatic pulse_selftest;
      selftest_exit_seq2 = 1'b1;
      cyc(1);
      selftest_exit_seq2 = 1'b0;
      cyc(3);
   endtask : pulse_selftest

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   initial begin
      srst = 1'b1;
      power_state_request_pin = 2'h0;
      sleep_pin = 2'h0;
      above_slow_uv = 3'h0;
      above_off_level = 3'h7;
      selftest_exit_seq2 = 1'b0;
      nvm_valid = 1'b1;
      cyc(10);
      srst = 1'b0;
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            sswl_host_model_inst.wr(rows[i].addr, rows[i].val);
         end else begin
            expect_rd(rows[i].addr, rows[i].val);
         end
      end
      // One lock register alone must not lock the group
      sswl_host_model_inst.wr(OFS_LOCK_PRIMARY, 8'h02);
      cyc(3);
      chk8({2'h0, group_locked_ff}, 8'h00);
      sswl_host_model_inst.wr(OFS_LOCK_SECOND, 8'h02);
      cyc(3);
      chk8({2'h0, group_locked_ff}, 8'h02);
      chk8({2'h0, chan_write_block_ff}, 8'h01);
      sswl_host_model_inst.wr(OFS_CHAN_LOCK_SEL, 8'h06);
      cyc(2);
      chk8({2'h0, chan_write_block_ff}, 8'h06);
      sswl_host_model_inst.wr(OFS_LOCK_PRIMARY, 8'hFF);
      sswl_host_model_inst.wr(OFS_LOCK_SECOND, 8'h00);
      expect_rd(OFS_LOCK_PRIMARY, 8'h3F);
      expect_rd(OFS_LOCK_SECOND, 8'h02);
      // Self-test clears locks only with the shutdown bit set
      pulse_selftest();
      expect_rd(OFS_LOCK_PRIMARY, 8'h3F);
      sswl_host_model_inst.wr(OFS_PAGE_SELECT, 8'h01);
      sswl_host_model_inst.wr(OFS_TEST_CONFIG, 8'h08);
      expect_rd(OFS_SUPV_CONTROL, 8'h00);
      pulse_selftest();
      expect_rd(OFS_LOCK_PRIMARY, 8'h00);
      // Full reset through the control register
      sswl_host_model_inst.wr(OFS_LOCK_PRIMARY, 8'h01);
      sswl_host_model_inst.wr(OFS_LOCK_SECOND, 8'h01);
      sswl_host_model_inst.wr(OFS_SUPV_CONTROL, 8'h08);
      cyc(3);
      chk8({2'h0, group_locked_ff}, 8'h00);
      expect_rd(OFS_LOCK_SECOND, 8'h00);
      expect_rd(OFS_CHAN_LOCK_SEL, 8'hC1);
      expect_rd(OFS_PAGE_SELECT, 8'h00);
      // Crossing while idle must not stamp
      above_slow_uv[2] = 1'b1;
      cyc(4);
      expect_rd(OFS_CH8_LO, 8'h00);
      power_state_request_pin = CODE_SEQ_UP;
      cyc(3 * TICK_CYCLES + TICK_CYCLES / 2);
      above_slow_uv[0] = 1'b1;
      cyc(4);
      expect_rd(OFS_CH6_HI, 8'h00);
      expect_rd(OFS_CH6_LO, 8'h03);
      above_slow_uv[0] = 1'b0;
      cyc(2);
      above_slow_uv[0] = 1'b1;
      cyc(TICK_CYCLES);
      expect_rd(OFS_CH6_LO, 8'h03);
      // Falling sequence launched from the sleep pin
      power_state_request_pin = 2'h0;
      sleep_pin = CODE_SEQ_DOWN;
      cyc(TICK_CYCLES + TICK_CYCLES / 2);
      above_off_level[1] = 1'b0;
      cyc(4);
      expect_rd(OFS_CH7_LO, 8'h01);
      expect_rd(OFS_CH6_LO, 8'h03);
      sleep_pin = 2'h0;
      // Factory upper bits stand in while one-time memory is not valid
      nvm_valid = 1'b0;
      expect_rd(OFS_BUS_ID, {1'b0, 4'hF, STRAP_SET});
      give_verdict();
   end
endmodule : sswl_tb_top
